// [logic/srr_status_regs.sv]
// status reporting register bank with wishbone slave and error queue
//
// Implementation choices: the Wishbone interface to the registers and the address map.
`timescale 1ns/1ps
`include "srr_defs.svh"
// Overview of operation
// - operation event cleared by clear-status or read
// - operation mask cleared at power-up, preset, write zero
// - error queue holds twenty entries, read FIFO
// - questionable condition read returns weighted sum
// - questionable mask selects summary contributors
// - operation condition uses only filter-settled bit
// - operation event bit eight latches settling
// - preset clears questionable and operation masks
// - clear-status clears all events and their summary bits; error queue kept
// - standard event mask selects summary contributors
// - standard event read returns weighted sum
// - operation complete sets standard event bit zero
// - completion query replies one after completion
// - power-on-clear setting decides standard event and service mask clearing
// - power-on-clear read returns stored setting
// - service mask selects request bits, readable
// - questionable and standard masks are readable
// - standard event cleared by clear-status or read
// - questionable bits: volts, temperature, ohms only
// - standard event bit meanings; bits one, six zero
module srr_status_regs #(
  parameter int ERRQ_DEPTH = `SRR_ERRQ_DEPTH,
  parameter int ERR_W = 16
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // register bus
  input srr_pkg::srr_wb_req_t wb_req_i,
  output srr_pkg::srr_wb_rsp_t wb_rsp_o,
  // measurement state
  input wire logic [15:0] ques_cond_i,
  input wire logic filter_settled_i,
  input srr_pkg::srr_sev_in_t sev_in_i,
  input wire logic cmds_done_i,
  // error queue fill
  input wire logic err_push_i,
  input wire logic [ERR_W-1:0] err_code_i,
  // non-volatile power-on-clear
  input wire logic psc_nv_i,
  output logic psc_o,
  output logic psc_save_o,
  // replies and service request
  output logic opc_reply_o,
  output logic [7:0] status_byte_o,
  output logic srq_o
);
  import srr_pkg::*;
  localparam int PW = (ERRQ_DEPTH > 1) ? $clog2(ERRQ_DEPTH) : 1;
  localparam int CW = $clog2(ERRQ_DEPTH + 1);

  // ==================================================
  // helpers
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    return a[7:2] == ofs[7:2];
  endfunction : hit

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (sel[i])
        r[i*8 +: 8] = nw[i*8 +: 8];
    end
    return r;
  endfunction : merge
  function automatic logic [PW-1:0] next_ptr(input logic [PW-1:0] p);
    return (p == PW'(ERRQ_DEPTH - 1)) ? '0 : PW'(p + 1'b1);
  endfunction : next_ptr

  // ==================================================
  // state
  logic ack_q;
  logic [31:0] rdat_q;
  logic [15:0] q_prev_q, q_ev_q, q_ev_d, q_en_q, q_en_d;
  logic o_prev_q;
  logic [15:0] o_ev_q, o_ev_d, o_en_q, o_en_d;
  logic [7:0] sev_q, sev_d, ese_q, ese_d, sre_q, sre_d, stb_q;
  logic psc_q, psc_save_q;
  logic opc_pend_q, opcq_pend_q, opc_reply_q;
  logic [ERR_W-1:0] errq_mem [ERRQ_DEPTH];
  logic [PW-1:0] wptr_q, rptr_q;
  logic [CW-1:0] ecnt_q, ecnt_d;

  // ==================================================
  // bus decode
  wire acc = wb_req_i.cyc & wb_req_i.stb & ~ack_q;
  wire wr = acc & wb_req_i.we;
  wire rd = acc & ~wb_req_i.we;
  wire [7:0] a = wb_req_i.adr;
  wire [31:0] wmrg_q = merge({16'h0000, q_en_q}, wb_req_i.dat, wb_req_i.sel);
  wire [31:0] wmrg_o = merge({16'h0000, o_en_q}, wb_req_i.dat, wb_req_i.sel);
  wire [31:0] wmrg_e = merge({24'h000000, ese_q}, wb_req_i.dat, wb_req_i.sel);
  wire [31:0] wmrg_s = merge({24'h000000, sre_q}, wb_req_i.dat, wb_req_i.sel);
  wire [31:0] wmrg_c = merge(32'h00000000, wb_req_i.dat, wb_req_i.sel);
  wire [31:0] wmrg_p = merge({31'h00000000, psc_q}, wb_req_i.dat, wb_req_i.sel);
  wire cmd_wr = wr & hit(a, `SRR_CMD_OFS);
  wire cls = cmd_wr & wmrg_c[`SRR_CMD_CLS_BIT];
  wire preset = cmd_wr & wmrg_c[`SRR_CMD_PRESET_BIT];
  wire opc_cmd = cmd_wr & wmrg_c[`SRR_CMD_OPC_BIT];
  wire opcq_cmd = cmd_wr & wmrg_c[`SRR_CMD_OPCQ_BIT];

  // ==================================================
  // condition and event registers
  wire [15:0] q_cond = ques_cond_i & `SRR_Q_USED;
  wire [15:0] q_rise = q_cond & ~q_prev_q;
  wire [15:0] o_cond = {7'h00, filter_settled_i, 8'h00};
  wire o_rise = filter_settled_i & ~o_prev_q;
  wire q_ev_clr = cls | (rd & hit(a, `SRR_QEVENT_OFS));
  wire o_ev_clr = cls | (rd & hit(a, `SRR_OEVENT_OFS));
  wire sev_clr = cls | (rd & hit(a, `SRR_SEVENT_OFS));
  wire opc_fire = opc_pend_q & cmds_done_i;
  // a reading overload also counts as a device error
  wire [7:0] sev_set = {2'b00, sev_in_i.cmd_err, sev_in_i.exec_err, sev_in_i.dev_err | (|q_rise),
                        sev_in_i.query_err, 1'b0, opc_fire};

  // set wins over a clear arriving in the same cycle
  assign q_ev_d = (q_ev_clr ? 16'h0000 : q_ev_q) | q_rise;
  assign o_ev_d = (o_ev_clr ? 16'h0000 : o_ev_q) | {7'h00, o_rise, 8'h00};
  assign sev_d = (sev_clr ? 8'h00 : sev_q) | sev_set;
  // ==================================================
  // enable masks; writing zero simply stores zero
  assign q_en_d = preset ? 16'h0000 : (wr & hit(a, `SRR_QENABLE_OFS)) ? wmrg_q[15:0] : q_en_q;
  assign o_en_d = preset ? 16'h0000 : (wr & hit(a, `SRR_OENABLE_OFS)) ? wmrg_o[15:0] : o_en_q;
  assign ese_d = (wr & hit(a, `SRR_SENABLE_OFS)) ? wmrg_e[7:0] : ese_q;
  assign sre_d = (wr & hit(a, `SRR_SRENABLE_OFS)) ? wmrg_s[7:0] : sre_q;
  wire psc_wr = wr & hit(a, `SRR_PSC_OFS);

  // ==================================================
  // error queue
  wire errq_ne = ecnt_q != '0;
  wire push = err_push_i & (ecnt_q != CW'(ERRQ_DEPTH)); // full queue drops new entries
  wire pop = rd & hit(a, `SRR_ERRQ_OFS) & errq_ne;
  assign ecnt_d = CW'(ecnt_q + CW'(push) - CW'(pop));
  wire [31:0] errq_head = errq_ne ? {{(32 - ERR_W){1'b0}}, errq_mem[rptr_q]} : 32'h00000000;

  // ==================================================
  // status byte
  wire [7:0] stb_raw = {|(o_ev_q & o_en_q), 1'b0, |(sev_q & ese_q), 2'b00,
                        errq_ne, 2'b00} | {4'h0, |(q_ev_q & q_en_q), 3'b000};
  wire mss = |(stb_raw & sre_q);
  wire [7:0] stb_d = stb_raw | {1'b0, mss, 6'h00};

  // ==================================================
  // read mux
  wire [31:0] rmux =
    ({32{hit(a, `SRR_QCOND_OFS)}} & {16'h0000, q_cond}) |
    ({32{hit(a, `SRR_QEVENT_OFS)}} & {16'h0000, q_ev_q}) |
    ({32{hit(a, `SRR_QENABLE_OFS)}} & {16'h0000, q_en_q}) |
    ({32{hit(a, `SRR_OCOND_OFS)}} & {16'h0000, o_cond}) |
    ({32{hit(a, `SRR_OEVENT_OFS)}} & {16'h0000, o_ev_q}) |
    ({32{hit(a, `SRR_OENABLE_OFS)}} & {16'h0000, o_en_q}) |
    ({32{hit(a, `SRR_SEVENT_OFS)}} & {24'h000000, sev_q}) |
    ({32{hit(a, `SRR_SENABLE_OFS)}} & {24'h000000, ese_q}) |
    ({32{hit(a, `SRR_SBYTE_OFS)}} & {24'h000000, stb_q}) |
    ({32{hit(a, `SRR_SRENABLE_OFS)}} & {24'h000000, sre_q}) |
    ({32{hit(a, `SRR_PSC_OFS)}} & {31'h00000000, psc_q}) |
    ({32{hit(a, `SRR_ERRQ_OFS)}} & errq_head) |
    ({32{hit(a, `SRR_ERRCNT_OFS)}} & {{(32 - CW){1'b0}}, ecnt_q});

  // ==================================================
  // flops
  always_ff @(posedge clk_i)
  begin
    ack_q <= rst_i ? 1'b0 : acc;
    rdat_q <= rst_i ? 32'h00000000 : (rd ? rmux : rdat_q);
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      q_prev_q <= 16'h0000;
      q_ev_q <= 16'h0000;
      q_en_q <= 16'h0000;
      o_prev_q <= 1'b0;
      o_ev_q <= 16'h0000;
      o_en_q <= 16'h0000;
      sev_q <= `SRR_SEV_RST;
      stb_q <= 8'h00;
    end
    else
    begin
      q_prev_q <= q_cond;
      q_ev_q <= q_ev_d;
      q_en_q <= q_en_d;
      o_prev_q <= filter_settled_i;
      o_ev_q <= o_ev_d;
      o_en_q <= o_en_d;
      sev_q <= sev_d;
      stb_q <= stb_d;
    end
  end

  // these masks survive power-up unless the stored setting asks to clear them
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      if (psc_nv_i)
      begin
        ese_q <= 8'h00;
        sre_q <= 8'h00;
      end
    end
    else
    begin
      ese_q <= ese_d;
      sre_q <= sre_d;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      psc_q <= psc_nv_i;
      psc_save_q <= 1'b0;
      opc_pend_q <= 1'b0;
      opcq_pend_q <= 1'b0;
      opc_reply_q <= 1'b0;
    end
    else
    begin
      psc_q <= psc_wr ? wmrg_p[0] : psc_q;
      psc_save_q <= psc_wr;
      opc_pend_q <= opc_cmd | (opc_pend_q & ~cmds_done_i);
      opcq_pend_q <= opcq_cmd | (opcq_pend_q & ~cmds_done_i);
      opc_reply_q <= opcq_pend_q & cmds_done_i;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wptr_q <= '0;
      rptr_q <= '0;
      ecnt_q <= '0;
    end
    else
    begin
      wptr_q <= push ? next_ptr(wptr_q) : wptr_q;
      rptr_q <= pop ? next_ptr(rptr_q) : rptr_q;
      ecnt_q <= ecnt_d;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (push)
      errq_mem[wptr_q] <= err_code_i;
  end

  // ==================================================
  // outputs
  assign wb_rsp_o.ack = ack_q;
  assign wb_rsp_o.dat = rdat_q;
  assign psc_o = psc_q;
  assign psc_save_o = psc_save_q;
  assign opc_reply_o = opc_reply_q;
  assign status_byte_o = stb_q;
  assign srq_o = stb_q[`SRR_STB_MSS_BIT];

  // ==================================================
  // assertions
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_oev_clr;
    rd && hit(a, `SRR_OEVENT_OFS) && !o_rise |=> o_ev_q == 16'h0000;
  endproperty
  a_oev_clr: assert property (p_oev_clr) else $error("operation event not cleared by read");
  property p_preset;
    preset |=> q_en_q == 16'h0000 && o_en_q == 16'h0000;
  endproperty
  a_preset: assert property (p_preset) else $error("preset left a mask set");
  property p_oen_zero;
    wr && hit(a, `SRR_OENABLE_OFS) && wmrg_o[15:0] == 16'h0000 |=> o_en_q == 16'h0000;
  endproperty
  a_oen_zero: assert property (p_oen_zero) else $error("operation mask not cleared by zero write");
  property p_errq_fifo;
    push && ecnt_q == '0 && !pop |=> errq_head == {{(32 - ERR_W){1'b0}}, $past(err_code_i)};
  endproperty
  a_errq_fifo: assert property (p_errq_fifo) else $error("error queue head wrong");
  property p_errq_max;
    ecnt_q <= CW'(ERRQ_DEPTH);
  endproperty
  a_errq_max: assert property (p_errq_max) else $error("error queue over depth");
  property p_qcond_rd;
    rd && hit(a, `SRR_QCOND_OFS) |=> ack_q && rdat_q == {16'h0000, $past(ques_cond_i) & `SRR_Q_USED};
  endproperty
  a_qcond_rd: assert property (p_qcond_rd) else $error("questionable condition read wrong");
  property p_qsum;
    ##1 stb_q[`SRR_STB_QUES_BIT] == $past(|(q_ev_q & q_en_q));
  endproperty
  a_qsum: assert property (p_qsum) else $error("questionable summary wrong");
  property p_esb;
    ##1 stb_q[`SRR_STB_ESB_BIT] == $past(|(sev_q & ese_q));
  endproperty
  a_esb: assert property (p_esb) else $error("standard event summary wrong");
  property p_oev_sticky;
    o_ev_q[`SRR_OP_SETTLED_BIT] && !o_ev_clr |=> o_ev_q[`SRR_OP_SETTLED_BIT];
  endproperty
  a_oev_sticky: assert property (p_oev_sticky) else $error("settled event lost");
  property p_cls;
    cls |=> (sev_q & ~$past(sev_set)) == 8'h00 && (q_ev_q & ~$past(q_rise)) == 16'h0000;
  endproperty
  a_cls: assert property (p_cls) else $error("clear-status left an event");
  property p_opc;
    opc_fire |=> sev_q[`SRR_SEV_OPC_BIT];
  endproperty
  a_opc: assert property (p_opc) else $error("operation complete bit not set");
  property p_opcq;
    opcq_cmd ##1 (!cmds_done_i [*2]) |=> !opc_reply_o;
  endproperty
  a_opcq: assert property (p_opcq) else $error("completion reply too early");
  property p_unused;
    sev_q[1] == 1'b0 && sev_q[6] == 1'b0 && (q_ev_q & ~`SRR_Q_USED) == 16'h0000;
  endproperty
  a_unused: assert property (p_unused) else $error("unused status bit set");
  property p_psc_rd;
    rd && hit(a, `SRR_PSC_OFS) |=> rdat_q == {31'h00000000, $past(psc_q)};
  endproperty
  a_psc_rd: assert property (p_psc_rd) else $error("power-on-clear read wrong");

  c_srq: cover property (!srq_o ##1 srq_o);
  c_errq_full: cover property (ecnt_q == CW'(ERRQ_DEPTH));
  c_opc_reply: cover property (opcq_cmd ##[1:20] opc_reply_o);
  c_settle_clr: cover property (o_ev_q[`SRR_OP_SETTLED_BIT] ##1 o_ev_clr);
endmodule : srr_status_regs

// [inc/srr_defs.svh]
// register offsets, field positions and reset values of the status reporting block
`ifndef SRR_DEFS_SVH
`define SRR_DEFS_SVH
// ==================================================
// register byte offsets
`define SRR_QCOND_OFS 8'h00
`define SRR_QEVENT_OFS 8'h04
`define SRR_QENABLE_OFS 8'h08
`define SRR_OCOND_OFS 8'h0c
`define SRR_OEVENT_OFS 8'h10
`define SRR_OENABLE_OFS 8'h14
`define SRR_SEVENT_OFS 8'h18
`define SRR_SENABLE_OFS 8'h1c
`define SRR_SBYTE_OFS 8'h20
`define SRR_SRENABLE_OFS 8'h24
`define SRR_CMD_OFS 8'h28
`define SRR_PSC_OFS 8'h2c
`define SRR_ERRQ_OFS 8'h30
`define SRR_ERRCNT_OFS 8'h34
// ==================================================
// field positions
`define SRR_Q_USED 16'h0211
`define SRR_OP_SETTLED_BIT 8
`define SRR_SEV_OPC_BIT 0
`define SRR_SEV_QRY_BIT 2
`define SRR_SEV_DEV_BIT 3
`define SRR_SEV_EXE_BIT 4
`define SRR_SEV_CMD_BIT 5
`define SRR_SEV_PON_BIT 7
`define SRR_STB_EAV_BIT 2
`define SRR_STB_QUES_BIT 3
`define SRR_STB_ESB_BIT 5
`define SRR_STB_MSS_BIT 6
`define SRR_STB_OPER_BIT 7
`define SRR_CMD_CLS_BIT 0
`define SRR_CMD_PRESET_BIT 1
`define SRR_CMD_OPC_BIT 2
`define SRR_CMD_OPCQ_BIT 3
// ==================================================
// reset values and sizes
`define SRR_SEV_RST 8'h80
`define SRR_ERRQ_DEPTH 20
`define SRR_ERR_CHARS 80
`endif

// [inc/srr_pkg.sv]
// types shared by the status reporting block
package srr_pkg;
  // ==================================================
  // wishbone carriers
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } srr_wb_req_t;
  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } srr_wb_rsp_t;
  // ==================================================
  // standard event sources, one-cycle pulses
  typedef struct packed {
    logic query_err;
    logic dev_err;
    logic exec_err;
    logic cmd_err;
  } srr_sev_in_t;
endpackage : srr_pkg

// [verif/srr_ctl_model.sv]
// remote controller model issuing register commands and queries
`timescale 1ns/1ps
module srr_ctl_model
  import srr_pkg::*;
(
  // clock
  input wire logic clk_i,
  // register bus
  input srr_pkg::srr_wb_rsp_t wb_rsp_i,
  output srr_pkg::srr_wb_req_t wb_req_o
);
  initial wb_req_o = '0;
  // ==================================================
  // one classic cycle
  // the request stays put until ack is seen at an edge, so the slave never sees a half-changed command
  task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk_i);
    wb_req_o <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hf, dat: wd};
    do
      @(posedge clk_i);
    while (wb_rsp_i.ack !== 1'b1);
    rd = wb_rsp_i.dat;
    wb_req_o <= '0;
  endtask : xfer
endmodule : srr_ctl_model

// [verif/test_srr_status_regs.sv]
// self-checking bench of the status reporting register bank
`timescale 1ns/1ps
`include "srr_defs.svh"
`define CHK(nm, e, a) check(nm, 32'(e), 32'(a))
module test_srr_status_regs;
  import srr_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  srr_wb_req_t wb_req;
  srr_wb_rsp_t wb_rsp;
  logic [15:0] ques_cond = '0;
  logic filter_settled = 1'b0;
  srr_sev_in_t sev_in = '0;
  logic cmds_done = 1'b1;
  logic err_push = 1'b0;
  logic [15:0] err_code = '0;
  logic psc_nv = 1'b1;
  logic psc, psc_save, opc_reply, srq;
  logic [7:0] status_byte;
  logic [31:0] d;
  int miscompares = 0;
  int num_checks = 0;
  int cycles = 0;
  int replies = 0;
  int saves = 0;
  // ==================================================
  // clock, instances, watchdog
  initial forever #12.5 clk_i = ~clk_i;
  srr_status_regs srr_status_regs_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req), .wb_rsp_o(wb_rsp),
    .ques_cond_i(ques_cond), .filter_settled_i(filter_settled), .sev_in_i(sev_in), .cmds_done_i(cmds_done),
    .err_push_i(err_push), .err_code_i(err_code), .psc_nv_i(psc_nv), .psc_o(psc), .psc_save_o(psc_save),
    .opc_reply_o(opc_reply), .status_byte_o(status_byte), .srq_o(srq));
  srr_ctl_model srr_ctl_model_inst (.clk_i(clk_i), .wb_rsp_i(wb_rsp), .wb_req_o(wb_req));
  always @(posedge clk_i)
  begin
    cycles++;
    if (opc_reply === 1'b1)
      replies++;
    if (psc_save === 1'b1)
      saves++;
    if (cycles == 20000)
    begin
      miscompares++;
      close_out();
    end
  end
  // ==================================================
  // helpers
  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] a);
    num_checks++;
    if (a !== e)
    begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, e, a);
    end
  endtask : check
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : close_out
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    srr_ctl_model_inst.xfer(1'b1, a, v, d);
  endtask : wr
  task automatic rc(input logic [7:0] a, input logic [31:0] e, input string nm);
    srr_ctl_model_inst.xfer(1'b0, a, '0, d);
    `CHK(nm, e, d);
  endtask : rc
  // lets event and summary registers catch up with the last input change
  task automatic settle();
    repeat (3) @(posedge clk_i);
  endtask : settle
  task automatic do_reset(input int n);
    rst_i <= 1'b1;
    repeat (n) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
  endtask : do_reset
  // ==================================================
  // test sequence
  initial
  begin
    do_reset(8);
    rc(`SRR_SEVENT_OFS, 8'h80, "power on event");
    rc(`SRR_SEVENT_OFS, 0, "event after read");
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clk_i);
      sev_in <= srr_sev_in_t'(4'h1 << i);
      @(posedge clk_i);
      sev_in <= '0;
    end
    rc(`SRR_SEVENT_OFS, 8'h3c, "error events");
    ques_cond <= 16'hffff;
    settle();
    rc(`SRR_QCOND_OFS, `SRR_Q_USED, "ques cond");
    wr(`SRR_QENABLE_OFS, 32'h0010);
    rc(`SRR_QENABLE_OFS, 32'h0010, "ques mask");
    settle();
    `CHK("ques summary on", 1, status_byte[`SRR_STB_QUES_BIT]);
    wr(`SRR_QENABLE_OFS, 32'h0002);
    settle();
    `CHK("ques summary off", 0, status_byte[`SRR_STB_QUES_BIT]);
    rc(`SRR_QEVENT_OFS, `SRR_Q_USED, "ques event");
    rc(`SRR_QEVENT_OFS, 0, "ques event cleared");
    ques_cond <= '0;
    filter_settled <= 1'b1;
    settle();
    rc(`SRR_OCOND_OFS, 32'h0100, "oper cond");
    filter_settled <= 1'b0;
    settle();
    rc(`SRR_OCOND_OFS, 0, "oper cond low");
    wr(`SRR_OENABLE_OFS, 32'h0100);
    settle();
    `CHK("oper summary", 1, status_byte[`SRR_STB_OPER_BIT]);
    rc(`SRR_OEVENT_OFS, 32'h0100, "oper event");
    rc(`SRR_OEVENT_OFS, 0, "oper event read");
    wr(`SRR_QENABLE_OFS, 32'h0211);
    wr(`SRR_CMD_OFS, 32'h2);
    rc(`SRR_QENABLE_OFS, 0, "ques mask preset");
    rc(`SRR_OENABLE_OFS, 0, "oper mask preset");
    wr(`SRR_OENABLE_OFS, 32'h0100);
    filter_settled <= 1'b1;
    wr(`SRR_SENABLE_OFS, 32'h08);
    sev_in <= '{dev_err: 1'b1, default: 1'b0};
    @(posedge clk_i);
    sev_in <= '0;
    wr(`SRR_SRENABLE_OFS, 32'h20);
    settle();
    `CHK("std summary", 8'he0, status_byte);
    `CHK("service request", 1, srq);
    rc(`SRR_SRENABLE_OFS, 32'h20, "service mask");
    rc(`SRR_SENABLE_OFS, 32'h08, "std mask");
    wr(`SRR_OENABLE_OFS, 0);
    rc(`SRR_OENABLE_OFS, 0, "oper mask zero");
    wr(`SRR_CMD_OFS, 32'h1);
    settle();
    `CHK("status byte cleared", 0, status_byte);
    rc(`SRR_OEVENT_OFS, 0, "oper event cls");
    rc(`SRR_SEVENT_OFS, 0, "std event cls");
    cmds_done <= 1'b0;
    wr(`SRR_CMD_OFS, 32'h4);
    wr(`SRR_CMD_OFS, 32'h8);
    settle();
    rc(`SRR_SEVENT_OFS, 0, "opc pending");
    `CHK("reply pending", 0, replies);
    cmds_done <= 1'b1;
    settle();
    `CHK("reply given", 1, replies);
    rc(`SRR_SEVENT_OFS, 1, "opc done");
    // one push more than the queue holds; the extra one must be dropped
    for (int i = 0; i <= `SRR_ERRQ_DEPTH; i++)
    begin
      err_push <= 1'b1;
      err_code <= 16'(i + 1);
      @(posedge clk_i);
    end
    err_push <= 1'b0;
    rc(`SRR_ERRCNT_OFS, `SRR_ERRQ_DEPTH, "error count");
    `CHK("queue summary", 8'h04, status_byte);
    for (int i = 0; i < `SRR_ERRQ_DEPTH; i++)
      rc(`SRR_ERRQ_OFS, i + 1, "error entry");
    rc(`SRR_ERRQ_OFS, 0, "error queue empty");
    rc(8'h3c, 0, "unmapped");
    wr(`SRR_PSC_OFS, 0);
    rc(`SRR_PSC_OFS, 0, "psc zero");
    `CHK("psc out zero", 0, psc);
    `CHK("psc save pulses", 1, saves);
    psc_nv <= 1'b0;
    wr(`SRR_SENABLE_OFS, 32'h3c);
    wr(`SRR_SRENABLE_OFS, 32'ha0);
    wr(`SRR_OENABLE_OFS, 32'h0100);
    do_reset(2);
    rc(`SRR_SENABLE_OFS, 32'h3c, "std mask kept");
    rc(`SRR_SRENABLE_OFS, 32'ha0, "service mask kept");
    rc(`SRR_OENABLE_OFS, 0, "oper mask power");
    rc(`SRR_PSC_OFS, 0, "psc after power");
    psc_nv <= 1'b1;
    do_reset(2);
    rc(`SRR_SENABLE_OFS, 0, "std mask cleared");
    rc(`SRR_SRENABLE_OFS, 0, "service mask cleared");
    rc(`SRR_PSC_OFS, 1, "psc one");
    `CHK("psc out one", 1, psc);
    close_out();
  end
endmodule : test_srr_status_regs
